// ### hw/acscr_consts.svh
// acscr_consts.svh: register map, field layout and timing constants
`ifndef ACSCR_CONSTS_SVH
`define ACSCR_CONSTS_SVH

`define ACSCR_OFS_CLK_STAT    8'h00
`define ACSCR_OFS_FW_ID       8'h01
`define ACSCR_OFS_ERR         8'h02
`define ACSCR_OFS_SYSCTL      8'h03

`define ACSCR_RST_CLK_STAT    8'h6c
`define ACSCR_RST_ERR         8'h00
`define ACSCR_RST_SYSCTL      8'h80
`define ACSCR_SYSCTL_WMASK    8'ha3
`define ACSCR_ERR_MASK        8'hfe

`define ACSCR_BIT_MCLK_ERR    7
`define ACSCR_BIT_LOCK_ERR    6
`define ACSCR_BIT_SCLK_ERR    5
`define ACSCR_BIT_LRCLK_ERR   4
`define ACSCR_BIT_SLIP        3
`define ACSCR_BIT_CLIP        2
`define ACSCR_BIT_PROT        1
`define ACSCR_BIT_DC_BLOCK    7
`define ACSCR_BIT_HARD_UNMUTE 5
`define ACSCR_DEEMPH_MSB      1
`define ACSCR_DEEMPH_LSB      0
`define ACSCR_RATE_MSB        7
`define ACSCR_RATE_LSB        5
`define ACSCR_RATIO_MSB       4
`define ACSCR_RATIO_LSB       2

`define ACSCR_RATE_32K        3'h0
`define ACSCR_RATE_48K        3'h3
`define ACSCR_RATE_16K        3'h4
`define ACSCR_RATE_24K        3'h5
`define ACSCR_RATE_8K         3'h6
`define ACSCR_RATE_12K        3'h7

`define ACSCR_RATIO_64        3'h0
`define ACSCR_RATIO_128       3'h1
`define ACSCR_RATIO_192       3'h2
`define ACSCR_RATIO_256       3'h3
`define ACSCR_RATIO_384       3'h4
`define ACSCR_RATIO_512       3'h5

// frame period bands in system clocks
`define ACSCR_TH_8K           16'h32c8
`define ACSCR_TH_12K          16'h2328
`define ACSCR_TH_16K          16'h1964
`define ACSCR_TH_24K          16'h1194
`define ACSCR_TH_32K          16'h0ce4
`define ACSCR_TH_FAM_12K      16'h2a76
`define ACSCR_TH_FAM_24K      16'h1536
`define ACSCR_TH_FAM_48K      16'h0aa0
// master clocks per frame bands
`define ACSCR_TH_R128         12'h060
`define ACSCR_TH_R192         12'h0a0
`define ACSCR_TH_R256         12'h0e0
`define ACSCR_TH_R384         12'h140
`define ACSCR_TH_R512         12'h1c0

`define ACSCR_SCLK_TOL        12'h001
`define ACSCR_SLIP_TOL        16'h0004
`define ACSCR_STABLE_FRAMES   3'h4
`define ACSCR_SEEN_FULL       2'h2
`define ACSCR_LOST_CYC        16'hffff
`define ACSCR_CNT_MAX         12'hfff

`define ACSCR_CLK_NS          8
`define ACSCR_STEP_SLOW_NS    125000
`define ACSCR_STEP_MID_NS     90700
`define ACSCR_STEP_FAST_NS    83300

`define ACSCR_SLEW_512        3'h0
`define ACSCR_SLEW_1024       3'h1
`define ACSCR_SLEW_2048       3'h2
`define ACSCR_SLEW_256        3'h3
`define ACSCR_LEN_256         12'h100
`define ACSCR_LEN_512         12'h200
`define ACSCR_LEN_1024        12'h400
`define ACSCR_LEN_2048        12'h800

`endif

// ### hw/acscr_pkg.sv
// acscr_pkg: state types of the clock status and control register block
package acscr_pkg;

    typedef enum logic [3:0] {
        ACSCR_IDLE    = 4'b0000,
        ACSCR_ADDR    = 4'b0001,
        ACSCR_ADDR_AK = 4'b0010,
        ACSCR_SUB     = 4'b0011,
        ACSCR_SUB_AK  = 4'b0100,
        ACSCR_WR      = 4'b0101,
        ACSCR_WR_AK   = 4'b0110,
        ACSCR_RD      = 4'b0111,
        ACSCR_RD_AK   = 4'b1000
    } acscr_bus_st_t;

    typedef struct packed {
        logic [2:0]       prev;
        logic [1:0][11:0] run_cnt;
        logic [15:0]      per_cnt;
        logic             frame;
        logic [15:0]      period;
        logic [1:0][11:0] cnt_out;
        logic             lost;
    } acscr_meter_t;

    typedef struct packed {
        logic        muted;
        logic [11:0] level;
        logic [13:0] tick;
    } acscr_ramp_t;

    typedef struct packed {
        acscr_bus_st_t st;
        logic [3:0]    bitcnt;
        logic [7:0]    shreg;
        logic [7:0]    sub;
        logic          rw;
        logic          scl_d;
        logic          sda_d;
        logic          sda_oe;
        logic          sda_out;
        logic [7:0]    clk_stat;
        logic [7:0]    err;
        logic [7:0]    sysctl;
        logic [15:0]   prev_period;
        logic [11:0]   prev_sclk;
        logic [1:0]    seen;
        logic [2:0]    stable;
        logic          lost_d;
    } acscr_main_t;

endpackage : acscr_pkg

// ### hw/acscr_frame_meter.sv
// acscr_frame_meter: measures frame period and clock edges per frame
`timescale 1ns/1ns
`include "acscr_consts.svh"
module acscr_frame_meter
    import acscr_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_mclk,
    input  wire logic        i_sclk,
    input  wire logic        i_lrclk,
    output logic             o_frame,
    output logic [15:0]      o_period,
    output logic [11:0]      o_mclk_cnt,
    output logic [11:0]      o_sclk_cnt,
    output logic             o_lost
);
    acscr_meter_t s;
    acscr_meter_t n;
    logic [1:0]   clk_in;
    logic [1:0]   rise;
    logic         lr_rise;

    assign clk_in  = {i_sclk, i_mclk};
    assign lr_rise = i_lrclk & ~s.prev[2];

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_edge
            assign rise[g] = clk_in[g] & ~s.prev[g];
        end
    endgenerate

    always_comb begin
        n       = s;
        n.prev  = {i_lrclk, clk_in};
        n.frame = 1'b0;
        if (lr_rise) begin
            n.period  = s.per_cnt;
            n.cnt_out = s.run_cnt;
            n.run_cnt = '0;
            n.per_cnt = 16'h0001;
            n.frame   = 1'b1;
            n.lost    = 1'b0;
        end else begin
            if (s.per_cnt != `ACSCR_LOST_CYC) begin
                n.per_cnt = s.per_cnt + 16'h0001;
            end else begin
                n.lost = 1'b1;
            end
            for (int i = 0; i < 2; i++) begin
                if (rise[i] && s.run_cnt[i] != `ACSCR_CNT_MAX) begin
                    n.run_cnt[i] = s.run_cnt[i] + 12'h001;
                end
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s      <= '0;
            s.lost <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign o_frame    = s.frame;
    assign o_period   = s.period;
    assign o_mclk_cnt = s.cnt_out[0];
    assign o_sclk_cnt = s.cnt_out[1];
    assign o_lost     = s.lost;

endmodule : acscr_frame_meter

// ### hw/acscr_unmute_ramp.sv
// acscr_unmute_ramp: mute on clock error and soft or hard recovery
`timescale 1ns/1ns
`include "acscr_consts.svh"
module acscr_unmute_ramp
    import acscr_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_clk_err,
    input  wire logic        i_clocks_ok,
    input  wire logic        i_hard,
    input  wire logic [2:0]  i_slew,
    input  wire logic [13:0] i_step_cyc,
    output logic             o_muted,
    output logic [11:0]      o_level
);
    acscr_ramp_t s;
    acscr_ramp_t n;
    logic [11:0] len;

    always_comb begin
        n = s;
        case (i_slew)
            `ACSCR_SLEW_1024: len = `ACSCR_LEN_1024;
            `ACSCR_SLEW_2048: len = `ACSCR_LEN_2048;
            `ACSCR_SLEW_256:  len = `ACSCR_LEN_256;
            default:          len = `ACSCR_LEN_512;
        endcase
        if (i_clk_err) begin
            n.muted = 1'b1;
            n.level = '0;
            n.tick  = '0;
        end else if (s.muted) begin
            if (i_clocks_ok) begin
                n.muted = 1'b0;
                if (i_hard) begin
                    n.level = len;
                end
            end
        end else if (s.level < len) begin
            if (s.tick >= i_step_cyc - 14'h0001) begin
                n.tick  = '0;
                n.level = s.level + 12'h001;
            end else begin
                n.tick = s.tick + 14'h0001;
            end
        end else begin
            n.level = len;
            n.tick  = '0;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s       <= '0;
            s.muted <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign o_muted = s.muted;
    assign o_level = s.level;

endmodule : acscr_unmute_ramp

// ### hw/acscr_regs.sv
// acscr_regs: serial-bus register bank with clock detection and error flags
`timescale 1ns/1ns
`include "acscr_consts.svh"
module acscr_regs
    import acscr_pkg::*;
#(
    parameter logic [6:0]  DEV_ADDR      = 7'h2a,
    // arbitrary identity value
    parameter logic [7:0]  FW_ID         = 8'h3c,
    parameter logic [13:0] STEP_CYC_SLOW = 14'(`ACSCR_STEP_SLOW_NS / `ACSCR_CLK_NS),
    parameter logic [13:0] STEP_CYC_MID  = 14'(`ACSCR_STEP_MID_NS / `ACSCR_CLK_NS),
    parameter logic [13:0] STEP_CYC_FAST = 14'(`ACSCR_STEP_FAST_NS / `ACSCR_CLK_NS)
) (
    input  wire logic        I_SYS_CLK,
    input  wire logic        I_NRST,
    input  wire logic        I_SCL,
    input  wire logic        I_SDA_IN,
    output logic             O_SDA_OUT,
    output logic             O_SDA_OE,
    input  wire logic        I_MCLK,
    input  wire logic        I_SCLK,
    input  wire logic        I_LRCLK,
    input  wire logic        I_CLIP,
    input  wire logic        I_PROT_FAULT,
    input  wire logic [2:0]  I_VOL_SLEW,
    output logic             O_DC_BLOCK_EN,
    output logic [1:0]       O_DEEMPH,
    output logic             O_MUTED,
    output logic [11:0]      O_RAMP_LEVEL
);
    acscr_main_t s;
    acscr_main_t n;

    logic        m_frame;
    logic [15:0] m_period;
    logic [11:0] m_mclk;
    logic [11:0] m_sclk;
    logic        m_lost;
    logic        scl_rise;
    logic        scl_fall;
    logic        start;
    logic        stop;
    logic        wr_en;
    logic [7:0]  rd_byte;
    logic [7:0]  set_err;
    logic [2:0]  rate;
    logic [2:0]  ratio;
    logic [15:0] per_diff;
    logic [11:0] sclk_diff;
    logic        fam44;
    logic        clk_err;
    logic        clocks_ok;
    logic [13:0] step_cyc;

    acscr_frame_meter u_meter (
        .i_clk      (I_SYS_CLK),
        .i_nrst     (I_NRST),
        .i_mclk     (I_MCLK),
        .i_sclk     (I_SCLK),
        .i_lrclk    (I_LRCLK),
        .o_frame    (m_frame),
        .o_period   (m_period),
        .o_mclk_cnt (m_mclk),
        .o_sclk_cnt (m_sclk),
        .o_lost     (m_lost)
    );

    acscr_unmute_ramp u_ramp (
        .i_clk       (I_SYS_CLK),
        .i_nrst      (I_NRST),
        .i_clk_err   (clk_err),
        .i_clocks_ok (clocks_ok),
        .i_hard      (s.sysctl[`ACSCR_BIT_HARD_UNMUTE]),
        .i_slew      (I_VOL_SLEW),
        .i_step_cyc  (step_cyc),
        .o_muted     (O_MUTED),
        .o_level     (O_RAMP_LEVEL)
    );

    // register read mux
    function automatic logic [7:0] read_reg(input logic [7:0] a, input acscr_main_t r);
        logic [7:0] d;
        d = 8'h00;
        if (a == `ACSCR_OFS_CLK_STAT) begin
            d = r.clk_stat;
        end else if (a == `ACSCR_OFS_FW_ID) begin
            d = FW_ID;
        end else if (a == `ACSCR_OFS_ERR) begin
            d = r.err;
        end else if (a == `ACSCR_OFS_SYSCTL) begin
            d = r.sysctl;
        end
        return d;
    endfunction : read_reg

    always_comb begin
        n         = s;
        n.scl_d   = I_SCL;
        n.sda_d   = I_SDA_IN;
        n.sda_out = 1'b0;
        scl_rise  = I_SCL & ~s.scl_d;
        scl_fall  = ~I_SCL & s.scl_d;
        start     = s.scl_d & I_SCL & s.sda_d & ~I_SDA_IN;
        stop      = s.scl_d & I_SCL & ~s.sda_d & I_SDA_IN;
        wr_en     = 1'b0;
        rd_byte   = read_reg(s.sub, s);

        // serial control bus slave
        if (start) begin
            n.st     = ACSCR_ADDR;
            n.bitcnt = '0;
            n.sda_oe = 1'b0;
        end else if (stop) begin
            n.st     = ACSCR_IDLE;
            n.sda_oe = 1'b0;
        end else begin
            case (s.st)
                ACSCR_ADDR, ACSCR_SUB, ACSCR_WR: begin
                    if (scl_rise) begin
                        n.shreg  = {s.shreg[6:0], I_SDA_IN};
                        n.bitcnt = s.bitcnt + 4'h1;
                    end else if (scl_fall && s.bitcnt == 4'h8) begin
                        n.sda_oe = 1'b1;
                        if (s.st == ACSCR_ADDR) begin
                            n.rw = s.shreg[0];
                            n.st = ACSCR_ADDR_AK;
                            if (s.shreg[7:1] != DEV_ADDR) begin
                                n.sda_oe = 1'b0;
                                n.st     = ACSCR_IDLE;
                            end
                        end else if (s.st == ACSCR_SUB) begin
                            n.sub = s.shreg;
                            n.st  = ACSCR_SUB_AK;
                        end else begin
                            wr_en = 1'b1;
                            n.sub = s.sub + 8'h01;
                            n.st  = ACSCR_WR_AK;
                        end
                    end
                end
                ACSCR_ADDR_AK: begin
                    if (scl_fall) begin
                        n.bitcnt = '0;
                        if (s.rw) begin
                            n.shreg  = rd_byte;
                            n.sda_oe = ~rd_byte[7];
                            n.st     = ACSCR_RD;
                        end else begin
                            n.sda_oe = 1'b0;
                            n.st     = ACSCR_SUB;
                        end
                    end
                end
                ACSCR_SUB_AK, ACSCR_WR_AK: begin
                    if (scl_fall) begin
                        n.sda_oe = 1'b0;
                        n.bitcnt = '0;
                        n.st     = ACSCR_WR;
                    end
                end
                ACSCR_RD: begin
                    if (scl_fall) begin
                        if (s.bitcnt == 4'h7) begin
                            n.sda_oe = 1'b0;
                            n.sub    = s.sub + 8'h01;
                            n.st     = ACSCR_RD_AK;
                        end else begin
                            n.shreg  = {s.shreg[6:0], 1'b0};
                            n.sda_oe = ~s.shreg[6];
                            n.bitcnt = s.bitcnt + 4'h1;
                        end
                    end
                end
                ACSCR_RD_AK: begin
                    if (scl_rise && I_SDA_IN) begin
                        n.st = ACSCR_IDLE;
                    end else if (scl_fall) begin
                        n.shreg  = rd_byte;
                        n.sda_oe = ~rd_byte[7];
                        n.bitcnt = '0;
                        n.st     = ACSCR_RD;
                    end
                end
                default: begin
                    n.st     = ACSCR_IDLE;
                    n.sda_oe = 1'b0;
                end
            endcase
        end

        if (m_period > `ACSCR_TH_8K) begin
            rate = `ACSCR_RATE_8K;
        end else if (m_period > `ACSCR_TH_12K) begin
            rate = `ACSCR_RATE_12K;
        end else if (m_period > `ACSCR_TH_16K) begin
            rate = `ACSCR_RATE_16K;
        end else if (m_period > `ACSCR_TH_24K) begin
            rate = `ACSCR_RATE_24K;
        end else if (m_period > `ACSCR_TH_32K) begin
            rate = `ACSCR_RATE_32K;
        end else begin
            rate = `ACSCR_RATE_48K;
        end
        // ratio from master clocks per frame
        if (m_mclk < `ACSCR_TH_R128) begin
            ratio = `ACSCR_RATIO_64;
        end else if (m_mclk < `ACSCR_TH_R192) begin
            ratio = `ACSCR_RATIO_128;
        end else if (m_mclk < `ACSCR_TH_R256) begin
            ratio = `ACSCR_RATIO_192;
        end else if (m_mclk < `ACSCR_TH_R384) begin
            ratio = `ACSCR_RATIO_256;
        end else if (m_mclk < `ACSCR_TH_R512) begin
            ratio = `ACSCR_RATIO_384;
        end else begin
            ratio = `ACSCR_RATIO_512;
        end

        per_diff  = (m_period > s.prev_period) ? m_period - s.prev_period
                                               : s.prev_period - m_period;
        sclk_diff = (m_sclk > s.prev_sclk) ? m_sclk - s.prev_sclk : s.prev_sclk - m_sclk;

        set_err = 8'h00;
        if (m_frame && s.seen == `ACSCR_SEEN_FULL) begin
            set_err[`ACSCR_BIT_MCLK_ERR] =
                ratio != s.clk_stat[`ACSCR_RATIO_MSB:`ACSCR_RATIO_LSB];
            set_err[`ACSCR_BIT_SCLK_ERR] = sclk_diff > `ACSCR_SCLK_TOL;
            set_err[`ACSCR_BIT_LRCLK_ERR] =
                rate != s.clk_stat[`ACSCR_RATE_MSB:`ACSCR_RATE_LSB];
            // phase drift within one rate band
            set_err[`ACSCR_BIT_SLIP] = ~set_err[`ACSCR_BIT_LRCLK_ERR]
                                       & (per_diff > `ACSCR_SLIP_TOL);
        end
        set_err[`ACSCR_BIT_LOCK_ERR] = m_lost & ~s.lost_d;
        set_err[`ACSCR_BIT_CLIP]     = I_CLIP;
        set_err[`ACSCR_BIT_PROT]     = I_PROT_FAULT;

        // sticky, written zero clears, set wins
        if (wr_en && s.sub == `ACSCR_OFS_ERR) begin
            n.err = ((s.err & s.shreg) | set_err) & `ACSCR_ERR_MASK;
        end else begin
            n.err = (s.err | set_err) & `ACSCR_ERR_MASK;
        end
        if (wr_en && s.sub == `ACSCR_OFS_SYSCTL) begin
            n.sysctl = s.shreg & `ACSCR_SYSCTL_WMASK;
        end

        n.lost_d = m_lost;
        if (m_lost) begin
            n.seen = '0;
        end else if (m_frame) begin
            n.clk_stat    = {rate, ratio, 2'b00};
            n.prev_period = m_period;
            n.prev_sclk   = m_sclk;
            if (s.seen != `ACSCR_SEEN_FULL) begin
                n.seen = s.seen + 2'h1;
            end
        end

        clk_err = m_lost | set_err[`ACSCR_BIT_MCLK_ERR] | set_err[`ACSCR_BIT_SCLK_ERR]
                  | set_err[`ACSCR_BIT_LRCLK_ERR] | set_err[`ACSCR_BIT_SLIP];
        if (clk_err) begin
            n.stable = '0;
        end else if (m_frame && s.seen == `ACSCR_SEEN_FULL
                     && s.stable != `ACSCR_STABLE_FRAMES) begin
            n.stable = s.stable + 3'h1;
        end
        clocks_ok = (s.stable == `ACSCR_STABLE_FRAMES) & ~m_lost;

        case (s.clk_stat[`ACSCR_RATE_MSB:`ACSCR_RATE_LSB])
            `ACSCR_RATE_12K: fam44 = m_period > `ACSCR_TH_FAM_12K;
            `ACSCR_RATE_24K: fam44 = m_period > `ACSCR_TH_FAM_24K;
            `ACSCR_RATE_48K: fam44 = m_period > `ACSCR_TH_FAM_48K;
            default:         fam44 = 1'b0;
        endcase
        case (s.clk_stat[`ACSCR_RATE_MSB:`ACSCR_RATE_LSB])
            `ACSCR_RATE_8K, `ACSCR_RATE_16K, `ACSCR_RATE_32K: step_cyc = STEP_CYC_SLOW;
            default: step_cyc = fam44 ? STEP_CYC_MID : STEP_CYC_FAST;
        endcase
    end

    always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            s          <= '0;
            s.st       <= ACSCR_IDLE;
            s.scl_d    <= 1'b1;
            s.sda_d    <= 1'b1;
            s.clk_stat <= `ACSCR_RST_CLK_STAT;
            s.err      <= `ACSCR_RST_ERR;
            s.sysctl   <= `ACSCR_RST_SYSCTL;
            s.lost_d   <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign O_SDA_OUT     = s.sda_out;
    assign O_SDA_OE      = s.sda_oe;
    assign O_DC_BLOCK_EN = s.sysctl[`ACSCR_BIT_DC_BLOCK];
    assign O_DEEMPH      = s.sysctl[`ACSCR_DEEMPH_MSB:`ACSCR_DEEMPH_LSB];

endmodule : acscr_regs

// ### testbench/acscr_regs_sva.sv
// acscr_regs_sva: port checks of the clock status and control block
`timescale 1ns/1ns
module acscr_regs_sva (
    input wire logic        I_SYS_CLK,
    input wire logic        I_NRST,
    input wire logic        I_SCL,
    input wire logic        O_SDA_OE,
    input wire logic        O_DC_BLOCK_EN,
    input wire logic [1:0]  O_DEEMPH,
    input wire logic        O_MUTED,
    input wire logic [11:0] O_RAMP_LEVEL
);
    default clocking @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_NRST);
    a_ctl_default: assert property ($rose(I_NRST) |-> O_DC_BLOCK_EN && O_DEEMPH == 2'h0)
        else $error("control defaults wrong");
    a_ctl_on_ack: assert property ($changed(O_DEEMPH) || $changed(O_DC_BLOCK_EN) |-> O_SDA_OE)
        else $error("control moved outside write");
    a_oe_scl_low: assert property ($changed(O_SDA_OE) |-> !$past(I_SCL))
        else $error("sda moved with scl high");
    a_level_cap: assert property (O_RAMP_LEVEL <= 12'h800)
        else $error("ramp level too high");
    a_muted_zero: assert property (O_MUTED && $past(O_MUTED) |-> O_RAMP_LEVEL == 12'h000)
        else $error("level while muted");
    a_mute_drop: assert property ($rose(O_MUTED) |-> ##[0:1] O_RAMP_LEVEL == 12'h000)
        else $error("level kept at mute");
    a_step_one: assert property (!O_MUTED && $changed(O_RAMP_LEVEL) |->
        O_RAMP_LEVEL == $past(O_RAMP_LEVEL) + 12'h001 || O_RAMP_LEVEL inside
        {12'h100, 12'h200, 12'h400, 12'h800}) else $error("ramp jump wrong");
    a_step_gap: assert property (!O_MUTED && O_RAMP_LEVEL == $past(O_RAMP_LEVEL) + 12'h001
        |=> ($stable(O_RAMP_LEVEL) || O_MUTED) [*4]) else $error("ramp steps too close");
endmodule : acscr_regs_sva
bind acscr_regs acscr_regs_sva acscr_regs_sva_inst (.I_SYS_CLK(I_SYS_CLK), .I_NRST(I_NRST),
    .I_SCL(I_SCL), .O_SDA_OE(O_SDA_OE), .O_DC_BLOCK_EN(O_DC_BLOCK_EN), .O_DEEMPH(O_DEEMPH),
    .O_MUTED(O_MUTED), .O_RAMP_LEVEL(O_RAMP_LEVEL));

// ### testbench/acscr_audio_src.sv
// acscr_audio_src: behavioural serial audio clock source
`timescale 1ns/1ns
module acscr_audio_src (
    input  wire logic [11:0] i_half,
    input  wire logic [11:0] i_ratio,
    output logic             o_mclk,
    output logic             o_sclk,
    output logic             o_lrclk
);
    int n;
    // 32 bit clocks a frame; clocks stand still while ratio is zero
    initial begin
        {o_mclk, o_sclk, o_lrclk} = 3'b000;
        forever begin
            if (i_ratio == 12'h000) #8;
            for (n = 0; n < i_ratio; n++) begin
                o_lrclk = n < i_ratio / 2;
                o_sclk = n % (i_ratio / 32) < i_ratio / 64;
                o_mclk = 1'b1;
                #(i_half) o_mclk = 1'b0;
                #(i_half);
            end
        end
    end
endmodule : acscr_audio_src

// ### testbench/acscr_regs_tb.sv
// acscr_regs_tb: bus, clock detection, error flag and unmute tests
`timescale 1ns/1ns
module acscr_regs_tb;
    localparam logic [6:0] ADDR = 7'h2a;
    localparam logic [7:0] FW   = 8'h5a; // arbitrary identity value
    logic        clk = 1'b0, nrst = 1'b0, scl = 1'b1, sda_m = 1'b1, clip = 1'b0, prot = 1'b0;
    logic [2:0]  slew = 3'h0;
    logic [11:0] half = 12'h000, ratio = 12'h000, level;
    logic        mclk, sclk, lrclk, oe, dc, muted, sdo;
    logic [1:0]  dm;
    logic [7:0]  r, d;
    logic [8:0]  q;
    logic [7:0]  rst_v [5] = '{8'h6c, FW, 8'h00, 8'h80, 8'h00};
    // legal rate and ratio pairs only
    logic [11:0] t_half [4] = '{12'h029, 12'h051, 12'h036, 12'h0a3};
    logic [11:0] t_ratio [4] = '{12'h100, 12'h0c0, 12'h180, 12'h040};
    logic [7:0]  t_stat [4] = '{8'h6c, 8'h08, 8'hb0, 8'h60};
    int          error_cnt = 0, tests_run = 0, e, i, k, frm;
    wire         sda = sda_m & ~oe;
    acscr_audio_src acscr_audio_src_inst (.i_half(half), .i_ratio(ratio), .o_mclk(mclk),
        .o_sclk(sclk), .o_lrclk(lrclk));
    acscr_regs #(.DEV_ADDR(ADDR), .FW_ID(FW), .STEP_CYC_SLOW(14'h0008),
        .STEP_CYC_MID(14'h0008), .STEP_CYC_FAST(14'h0008)) acscr_regs_inst (
        .I_SYS_CLK(clk), .I_NRST(nrst), .I_SCL(scl), .I_SDA_IN(sda), .O_SDA_OUT(sdo),
        .O_SDA_OE(oe), .I_MCLK(mclk), .I_SCLK(sclk), .I_LRCLK(lrclk), .I_CLIP(clip),
        .I_PROT_FAULT(prot), .I_VOL_SLEW(slew), .O_DC_BLOCK_EN(dc), .O_DEEMPH(dm),
        .O_MUTED(muted), .O_RAMP_LEVEL(level));
    initial forever #4 clk = ~clk;
    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask : w
    task automatic chk(input string nm, input logic [11:0] s, input logic [11:0] x);
        tests_run++;
        if (s !== x) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, x, s);
        end
    endtask : chk
    // scl low, data a, scl high, data b: start, stop or one bit
    task automatic seq(input logic a, input logic b);
        scl = 1'b0;
        w(3);
        sda_m = a;
        w(3);
        scl = 1'b1;
        w(3);
        sda_m = b;
        w(3);
    endtask : seq
    task automatic xfer(input logic [8:0] v, input logic ak);
        for (int j = 8; j >= 0; j--) begin
            seq(v[j], v[j]);
            q[j] = sda;
        end
        if (ak) chk("ack", q[0], 1'b0);
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        seq(1'b1, 1'b0);
        xfer({ADDR, 2'b01}, 1'b1);
        xfer({a, 1'b1}, 1'b1);
        xfer({v, 1'b1}, 1'b1);
        seq(1'b0, 1'b1);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        seq(1'b1, 1'b0);
        xfer({ADDR, 2'b01}, 1'b1);
        xfer({a, 1'b1}, 1'b1);
        seq(1'b1, 1'b0);
        xfer({ADDR, 2'b11}, 1'b1);
        xfer(9'h1ff, 1'b0);
        r = q[8:1];
        seq(1'b0, 1'b1);
    endtask : rd
    task automatic tally_and_finish;
        if (error_cnt == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        w(6);
        nrst = 1'b1;
        for (k = 0; k < 2; k++) begin
            for (i = 0; i < 5; i++) begin
                rd(8'(i));
                chk("reg", r, rst_v[i]);
            end
            wr(8'h00, 8'h00);
            wr(8'h01, 8'h00);
            wr(8'h04, 8'h55);
        end
        for (k = 0; k < 4; k++) begin
            d = {k[0], 1'b0, k[1], 3'b000, k[1:0]};
            wr(8'h03, d);
            rd(8'h03);
            chk("sysctl", r, {d[7], 1'b0, d[5], 3'b000, d[1:0]});
            chk("deemph", dm, k[1:0]);
            chk("dc_block", dc, k[0]);
        end
        for (e = 0; e < 4; e++) begin
            if (e == 1) begin
                wr(8'h03, 8'h80);
                slew = 3'h3;
            end
            half = t_half[e];
            ratio = t_ratio[e];
            frm = int'(t_ratio[e]) * int'(t_half[e]) / 4;
            w(2 * frm + 200);
            rd(8'h00);
            chk("clk_stat", r, t_stat[e]);
            if (e < 2) begin
                for (i = 0; i < 8 * frm && muted; i++) w(1);
                chk("unmuted", muted, 1'b0);
                w(1024);
                chk("ramp_mid", e == 0 ? level == 12'h200 : level inside {[12'h07e:12'h081]}, 1'b1);
                w(1040);
                chk("ramp_end", level, e == 0 ? 12'h200 : 12'h100);
            end
            rd(8'h02);
            if (e > 0) chk("clk_err", r & 8'h90, 8'h90);
            wr(8'h02, 8'h00);
            w(frm);
            rd(8'h02);
            chk("err_clear", r, 8'h00);
        end
        clip = 1'b1;
        prot = 1'b1;
        w(1);
        clip = 1'b0;
        prot = 1'b0;
        rd(8'h02);
        chk("clip_prot", r, 8'h06);
        wr(8'h02, 8'hfb);
        rd(8'h02);
        chk("clip_clear", r, 8'h02);
        chk("sda_out", sdo, 1'b0);
        tally_and_finish;
    end
endmodule : acscr_regs_tb
